// ===== hw/cpu_add_and_branch_exec.v
// execution slice: add, and, bit clear and carry/negative branches
`timescale 1ns/10ps
`default_nettype none
`include "cpu_exec_consts.vh"

module cpu_add_and_branch_exec #(
  parameter ADDR_W = 12,
  parameter PC_W   = 21
) (
  // clock and reset
  input  wire              sys_clk_in,
  input  wire              reset_in,
  // program memory
  input  wire [15:0]       instr_in,
  output reg  [PC_W-1:0]   pc_out,
  // data memory
  input  wire [7:0]        dmem_rdata_in,
  output reg  [ADDR_W-1:0] dmem_addr_out,
  output reg  [7:0]        dmem_wdata_out,
  output reg               dmem_we_out,
  // configuration
  input  wire              ext_set_in,
  input  wire [3:0]        bank_select_reg_in,
  input  wire [ADDR_W-1:0] index_base_in,
  input  wire              prescaler_assigned_in,
  // port pins
  input  wire [7:0]        port_pins_in,
  // core state
  output reg  [7:0]        working_reg_out,
  output reg  [4:0]        status_out,
  output reg               prescaler_clear_out,
  output reg               nop_cycle_out
);

  ////////////////////////////////////////////////////////////////////////
  // phase states
  localparam [3:0] PH_Q1 = 4'b0001;
  localparam [3:0] PH_Q2 = 4'b0010;
  localparam [3:0] PH_Q3 = 4'b0100;
  localparam [3:0] PH_Q4 = 4'b1000;

  reg [3:0]  phase_q;
  reg [15:0] ir_q;
  reg        kill_q;
  reg [7:0]  opnd_q;
  reg [8:0]  sum_q;
  reg        dc_q;
  reg [7:0]  res_q;
  reg [7:0]  pin_meta_q;
  reg [7:0]  pin_sync_q;

  ////////////////////////////////////////////////////////////////////////
  // pin synchroniser
  always @(posedge sys_clk_in) begin
    if (reset_in) begin
      pin_meta_q <= 8'h00;
      pin_sync_q <= 8'h00;
    end else begin
      pin_meta_q <= port_pins_in;
      pin_sync_q <= pin_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // decode of the latched word
  wire is_add_reg   = ~kill_q & (ir_q[15:10] == `OPC6_ADD_REG);
  wire is_addc_reg  = ~kill_q & (ir_q[15:10] == `OPC6_ADD_CARRY_REG);
  wire is_and_reg   = ~kill_q & (ir_q[15:10] == `OPC6_AND_REG);
  wire is_add_lit   = ~kill_q & (ir_q[15:8] == `OPC8_ADD_LITERAL);
  wire is_and_lit   = ~kill_q & (ir_q[15:8] == `OPC8_AND_LITERAL);
  wire is_br_carry  = ~kill_q & (ir_q[15:8] == `OPC8_BRANCH_CARRY);
  wire is_br_neg    = ~kill_q & (ir_q[15:8] == `OPC8_BRANCH_NEG);
  wire is_bit_clear = ~kill_q & (ir_q[15:12] == `OPC4_BIT_CLEAR);
  // second words and other encodings fall through as no-operation
  wire is_reg_op = is_add_reg | is_addc_reg | is_and_reg | is_bit_clear;
  wire is_lit_op = is_add_lit | is_and_lit;
  wire is_add    = is_add_reg | is_addc_reg | is_add_lit;
  wire is_and    = is_and_reg | is_and_lit;
  wire to_file   = is_bit_clear | ((is_add_reg | is_addc_reg | is_and_reg)
                   & ir_q[`DEST_BIT]);
  wire to_w      = is_lit_op | ((is_add_reg | is_addc_reg | is_and_reg)
                   & ~ir_q[`DEST_BIT]);
  wire br_taken  = (is_br_carry & status_out[`FLAG_C])
                 | (is_br_neg & status_out[`FLAG_N]);

  ////////////////////////////////////////////////////////////////////////
  // effective data address from the word on the bus
  wire [7:0] f_field  = instr_in[7:0];
  wire       a_field  = instr_in[`ACCESS_BIT];
  reg  [ADDR_W-1:0] eff_addr;
  always @* begin
    eff_addr = {ADDR_W{1'b0}};
    if (a_field) begin
      eff_addr = {bank_select_reg_in, f_field};
    end else if (ext_set_in && (f_field <= `INDEXED_LIMIT)) begin
      eff_addr = index_base_in + {4'h0, f_field};
    end else if (f_field < `ACCESS_SPLIT) begin
      eff_addr = {4'h0, f_field};
    end else begin
      eff_addr = {`ACCESS_HIGH_PAGE, f_field};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // arithmetic
  wire [7:0] src_b   = is_lit_op ? ir_q[7:0] : opnd_q;
  wire       cin     = is_addc_reg & status_out[`FLAG_C];
  wire [8:0] sum_d   = {1'b0, working_reg_out} + {1'b0, src_b}
                     + {8'h00, cin};
  wire [4:0] lo_sum  = {1'b0, working_reg_out[3:0]} + {1'b0, src_b[3:0]}
                     + {4'h0, cin};
  wire [7:0] clr_msk = ~(8'h01 << ir_q[11:9]);
  reg  [7:0] res_d;
  always @* begin
    res_d = 8'h00;
    if (is_add) begin
      res_d = sum_d[7:0];
    end else if (is_and) begin
      res_d = working_reg_out & src_b;
    end else if (is_bit_clear) begin
      res_d = opnd_q & clr_msk;
    end
  end
  wire ov_d = (working_reg_out[7] == src_b[7])
            & (sum_q[7] != working_reg_out[7]);

  ////////////////////////////////////////////////////////////////////////
  // branch target
  wire [PC_W-1:0] br_off = {{(PC_W-9){ir_q[7]}}, ir_q[7:0], 1'b0};
  wire [PC_W-1:0] br_tgt = pc_out + `PC_STEP + br_off;

  ////////////////////////////////////////////////////////////////////////
  // flag update for the write phase
  reg [4:0] status_d;
  always @* begin
    status_d = status_out;
    if (is_add) begin
      status_d[`FLAG_C]  = sum_q[8];
      status_d[`FLAG_DC] = dc_q;
      status_d[`FLAG_OV] = ov_d;
    end
    if (is_add | is_and) begin
      status_d[`FLAG_N] = res_q[7];
      status_d[`FLAG_Z] = (res_q == 8'h00);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // program counter and forced no-operation cycle
  reg [PC_W-1:0] pc_d;
  reg            kill_d;
  reg            nop_d;
  always @* begin
    pc_d   = pc_out + `PC_STEP;
    kill_d = 1'b0;
    nop_d  = 1'b0;
    if (br_taken) begin
      pc_d   = br_tgt;
      kill_d = 1'b1;
      nop_d  = 1'b1;
    end else if (kill_q) begin
      // the word fetched behind a taken branch is dropped
      pc_d   = pc_out;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // phase sequencer
  always @(posedge sys_clk_in) begin
    if (reset_in) begin
      phase_q <= PH_Q1;
    end else begin
      case (phase_q)
        PH_Q1: begin
          phase_q <= PH_Q2;
        end
        PH_Q2: begin
          phase_q <= PH_Q3;
        end
        PH_Q3: begin
          phase_q <= PH_Q4;
        end
        PH_Q4: begin
          phase_q <= PH_Q1;
        end
        default: begin
          phase_q <= PH_Q1;
        end
      endcase
    end
  end

  wire in_q1 = (phase_q == PH_Q1);
  wire in_q2 = (phase_q == PH_Q2);
  wire in_q3 = (phase_q == PH_Q3);
  wire in_q4 = (phase_q == PH_Q4);

  ////////////////////////////////////////////////////////////////////////
  // decode phase: latch the word and the data address
  always @(posedge sys_clk_in) begin
    if (reset_in) begin
      ir_q          <= 16'h0000;
      dmem_addr_out <= {ADDR_W{1'b0}};
    end else if (in_q1) begin
      ir_q          <= instr_in;
      dmem_addr_out <= eff_addr;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read phase: the port address reads the synchronised pins
  always @(posedge sys_clk_in) begin
    if (reset_in) begin
      opnd_q <= 8'h00;
    end else if (in_q2) begin
      if (dmem_addr_out == `PORT_REG_ADDR) begin
        opnd_q <= pin_sync_q;
      end else begin
        opnd_q <= dmem_rdata_in;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // process phase
  always @(posedge sys_clk_in) begin
    if (reset_in) begin
      res_q <= 8'h00;
      sum_q <= 9'h000;
      dc_q  <= 1'b0;
    end else if (in_q3) begin
      res_q <= res_d;
      sum_q <= sum_d;
      dc_q  <= lo_sum[4];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // write phase: data memory port and prescaler clear
  always @(posedge sys_clk_in) begin
    if (reset_in) begin
      dmem_wdata_out      <= 8'h00;
      dmem_we_out         <= 1'b0;
      prescaler_clear_out <= 1'b0;
    end else begin
      dmem_we_out         <= 1'b0;
      prescaler_clear_out <= 1'b0;
      if (in_q4 && to_file) begin
        dmem_wdata_out <= res_q;
        dmem_we_out    <= 1'b1;
        if ((dmem_addr_out == `TIMER_ZERO_ADDR)
            && prescaler_assigned_in) begin
          prescaler_clear_out <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // write phase: working register, flags and program counter
  always @(posedge sys_clk_in) begin
    if (reset_in) begin
      working_reg_out <= `RESET_W;
      status_out      <= `RESET_STATUS;
      pc_out          <= `RESET_PC;
      kill_q          <= 1'b0;
      nop_cycle_out   <= 1'b0;
    end else if (in_q4) begin
      if (to_w) begin
        working_reg_out <= res_q;
      end
      status_out    <= status_d;
      pc_out        <= pc_d;
      kill_q        <= kill_d;
      nop_cycle_out <= nop_d;
    end
  end

endmodule // cpu_add_and_branch_exec
`default_nettype wire

// ===== hw/cpu_exec_consts.vh
// constants for the add, and, bit clear and branch execution slice
// Summary of operation
// - port self-update reads live pin levels
// - timer zero write clears assigned prescaler
// - taken branch adds one no-operation cycle
// - lone second instruction word is no-operation
// - register add updates five arithmetic flags
// - destination bit zero picks working register
// - access bit picks quick bank or banked
// - extended set low offsets use indexed addressing
// - add with carry sums three operands
// - carry and negative branches jump when set
// - taken branch target is pc+2+2n
// - bit clear changes one bit, no flags
`ifndef CPU_EXEC_CONSTS_VH
`define CPU_EXEC_CONSTS_VH
// opcode fields
`define OPC6_ADD_REG        6'h09
`define OPC6_ADD_CARRY_REG  6'h08
`define OPC6_AND_REG        6'h05
`define OPC8_ADD_LITERAL    8'h0F
`define OPC8_AND_LITERAL    8'h0B
`define OPC8_BRANCH_CARRY   8'hE2
`define OPC8_BRANCH_NEG     8'hE6
`define OPC4_BIT_CLEAR      4'h9
`define OPC4_SECOND_WORD    4'hF
// instruction field positions
`define DEST_BIT            9
`define ACCESS_BIT          8
// addressing
`define ACCESS_SPLIT        8'h80
`define ACCESS_HIGH_PAGE    4'hF
`define INDEXED_LIMIT       8'h5F
`define PORT_REG_ADDR       12'hF81
`define TIMER_ZERO_ADDR     12'hFD6
// status bit positions
`define FLAG_C              0
`define FLAG_DC             1
`define FLAG_Z              2
`define FLAG_OV             3
`define FLAG_N              4
// reset values and program counter step
`define RESET_PC            21'h000000
`define RESET_W             8'h00
`define RESET_STATUS        5'h00
`define PC_STEP             21'h000002
`endif

// ===== testbench/cpu_exec_asserts.sv
// timing checks on the ports of the execution slice
`timescale 1ns/10ps
`default_nettype none
module cpu_exec_asserts #(
  parameter ADDR_W = 12,
  parameter PC_W   = 21
) (
  // clock and reset
  input wire logic              sys_clk_in,
  input wire logic              reset_in,
  // watched ports
  input wire logic [15:0]       instr_in,
  input wire logic [PC_W-1:0]   pc_out,
  input wire logic [ADDR_W-1:0] dmem_addr_out,
  input wire logic              dmem_we_out,
  input wire logic              prescaler_assigned_in,
  input wire logic              prescaler_clear_out,
  input wire logic              nop_cycle_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (reset_in);
  ////////////////////////////////////////////////////////////////////////////
  we_pulse_a: assert property (dmem_we_out |=> !dmem_we_out)
    else $error("write strobe longer than one clock");
  clr_cause_a: assert property (prescaler_clear_out |->
    dmem_we_out && dmem_addr_out == 12'hFD6 && $past(prescaler_assigned_in))
    else $error("prescaler clear without timer write");
  clr_due_a: assert property (dmem_we_out &&
    dmem_addr_out == 12'hFD6 && $past(prescaler_assigned_in) |->
    prescaler_clear_out)
    else $error("timer write left prescaler alone");
  nop_len_a: assert property ($rose(nop_cycle_out) |->
    nop_cycle_out [*4] ##1 !nop_cycle_out)
    else $error("no-op cycle not four clocks");
  nop_pc_hold_a: assert property (nop_cycle_out |=>
    $stable(pc_out))
    else $error("pc moved during no-op cycle");
  nop_no_write_a: assert property (nop_cycle_out |->
    !dmem_we_out)
    else $error("write during no-op cycle");
  pc_advance_a: assert property ($changed(pc_out) &&
    !$rose(nop_cycle_out) |-> pc_out == $past(pc_out) + 2)
    else $error("pc step not two");
  // sum cut back to the counter width so backward branches wrap
  branch_target_a: assert property ($rose(nop_cycle_out) |->
    pc_out == PC_W'($past(pc_out) + 2 +
    {{(PC_W-9){$past(instr_in[7], 4)}}, $past(instr_in[7:0], 4), 1'b0}))
    else $error("branch target wrong");
endmodule // cpu_exec_asserts
bind cpu_add_and_branch_exec cpu_exec_asserts #(.ADDR_W(ADDR_W), .PC_W(PC_W))
  cpu_exec_asserts_i (.sys_clk_in(sys_clk_in), .reset_in(reset_in),
  .instr_in(instr_in), .pc_out(pc_out), .dmem_addr_out(dmem_addr_out),
  .dmem_we_out(dmem_we_out), .prescaler_assigned_in(prescaler_assigned_in),
  .prescaler_clear_out(prescaler_clear_out), .nop_cycle_out(nop_cycle_out));
`default_nettype wire

// ===== testbench/exec_mem_model.sv
// program and data memory model facing the execution slice
`timescale 1ns/10ps
`default_nettype none
module exec_mem_model (
  // clock
  input  wire logic        sys_clk_in,
  // program side
  input  wire logic [20:0] pc_in,
  output logic      [15:0] instr_out,
  // data side
  input  wire logic [11:0] addr_in,
  input  wire logic [7:0]  wdata_in,
  input  wire logic        we_in,
  output logic      [7:0]  rdata_out
);
  logic [15:0] prog_q [0:63];
  logic [7:0]  data_q [0:4095];
  initial begin
    for (int i = 0; i < 4096; i++) begin
      data_q[i] = 8'h00;
      if (i < 64) prog_q[i] = 16'h0000;
    end
  end
  // beyond the loaded program the fetch sees no-operation words
  assign instr_out = (pc_in[20:7] == 14'h0) ? prog_q[pc_in[6:1]] : 16'h0000;
  assign rdata_out = data_q[addr_in];
  always @(posedge sys_clk_in) begin
    if (we_in) data_q[addr_in] <= wdata_in;
  end
endmodule // exec_mem_model
`default_nettype wire

// ===== testbench/cpu_add_and_branch_exec_test.sv
// self-checking bench for the execution slice
`timescale 1ns/10ps
`default_nettype none
module cpu_add_and_branch_exec_test;
  logic        sys_clk_in = 1'b0;
  logic        reset_in   = 1'b1;
  logic        ext_set_in = 1'b0;
  logic [15:0] instr;
  logic [20:0] pc_out;
  logic [7:0]  rdata, wdata, working_reg_out;
  logic [11:0] addr;
  logic [4:0]  status_out;
  logic        we, pclr, nop;
  int          fail_count = 0;
  int          n_checks   = 0;
  int          cyc        = 0;
  int          ahead      = 0;
  logic        assigned   = 1'b1;
  logic [15:0] prog [0:20] = '{16'h0F7F, 16'h0F01, 16'h0F80, 16'hE202,
    16'h0FFF, 16'h0FFF, 16'h0B5F, 16'h0FC2, 16'h2510, 16'h2310, 16'h1610,
    16'h9610, 16'h2681, 16'h16D6, 16'h14D6, 16'h16D6, 16'hF123, 16'h2405,
    16'hE603, 16'h0F70, 16'hE6FE};
  cpu_add_and_branch_exec cpu_add_and_branch_exec_i (
    .sys_clk_in(sys_clk_in), .reset_in(reset_in), .instr_in(instr),
    .pc_out(pc_out), .dmem_rdata_in(rdata), .dmem_addr_out(addr),
    .dmem_wdata_out(wdata), .dmem_we_out(we), .ext_set_in(ext_set_in),
    .bank_select_reg_in(4'h2), .index_base_in(12'h300),
    .prescaler_assigned_in(assigned), .port_pins_in(8'h30),
    .working_reg_out(working_reg_out), .status_out(status_out),
    .prescaler_clear_out(pclr), .nop_cycle_out(nop));
  exec_mem_model exec_mem_model_i (.sys_clk_in(sys_clk_in), .pc_in(pc_out),
    .instr_out(instr), .addr_in(addr), .wdata_in(wdata), .we_in(we),
    .rdata_out(rdata));
  ////////////////////////////////////////////////////////////////////////////
  initial forever #25 sys_clk_in = ~sys_clk_in;
  task automatic wrap_up();
    if (fail_count == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge sys_clk_in) begin
    cyc++;
    if (cyc == 1000) begin
      fail_count++;
      wrap_up();
    end
  end
  task automatic chk(input logic [20:0] got, input logic [20:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one instruction cycle, then the core state after its write phase
  task automatic step(input logic [20:0] p, input logic [7:0] w,
                      input logic [4:0] s, input logic n, input logic c);
    repeat (4 - ahead) @(posedge sys_clk_in);
    ahead = 0;
    @(negedge sys_clk_in);
    chk(pc_out, p);
    chk(21'(working_reg_out), 21'(w));
    chk(21'(status_out), 21'(s));
    chk(21'(nop), 21'(n));
    chk(21'(pclr), 21'(c));
  endtask
  // the write lands at the clock edge after the write phase
  task automatic mem(input logic [11:0] a, input logic [7:0] v);
    if (ahead == 0) begin
      @(posedge sys_clk_in);
      #1;
      ahead = 1;
    end
    chk(21'(exec_mem_model_i.data_q[a]), 21'(v));
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #1;
    for (int i = 0; i < 21; i++) exec_mem_model_i.prog_q[i] = prog[i];
    exec_mem_model_i.data_q[12'h210] = 8'h4D;
    exec_mem_model_i.data_q[12'h010] = 8'h3C;
    exec_mem_model_i.data_q[12'hF81] = 8'hFF;
    exec_mem_model_i.data_q[12'hFD6] = 8'hFF;
    exec_mem_model_i.data_q[12'h305] = 8'h01;
    repeat (12) @(negedge sys_clk_in);
    reset_in = 1'b0;
    step(21'h02, 8'h7F, 5'h00, 1'b0, 1'b0);
    step(21'h04, 8'h80, 5'h1A, 1'b0, 1'b0);
    step(21'h06, 8'h00, 5'h0D, 1'b0, 1'b0);
    step(21'h0C, 8'h00, 5'h0D, 1'b1, 1'b0);
    step(21'h0C, 8'h00, 5'h0D, 1'b0, 1'b0);
    step(21'h0E, 8'h00, 5'h0D, 1'b0, 1'b0);
    step(21'h10, 8'hC2, 5'h10, 1'b0, 1'b0);
    step(21'h12, 8'h0F, 5'h01, 1'b0, 1'b0);
    step(21'h14, 8'h0F, 5'h02, 1'b0, 1'b0);
    mem(12'h210, 8'h5D);
    step(21'h16, 8'h0F, 5'h02, 1'b0, 1'b0);
    mem(12'h010, 8'h0C);
    step(21'h18, 8'h0F, 5'h02, 1'b0, 1'b0);
    mem(12'h010, 8'h04);
    step(21'h1A, 8'h0F, 5'h00, 1'b0, 1'b0);
    mem(12'hF81, 8'h3F);
    step(21'h1C, 8'h0F, 5'h00, 1'b0, 1'b1);
    mem(12'hFD6, 8'h0F);
    step(21'h1E, 8'h0F, 5'h00, 1'b0, 1'b0);
    assigned = 1'b0;
    step(21'h20, 8'h0F, 5'h00, 1'b0, 1'b0);
    step(21'h22, 8'h0F, 5'h00, 1'b0, 1'b0);
    ext_set_in = 1'b1;
    step(21'h24, 8'h10, 5'h02, 1'b0, 1'b0);
    step(21'h26, 8'h10, 5'h02, 1'b0, 1'b0);
    step(21'h28, 8'h80, 5'h18, 1'b0, 1'b0);
    step(21'h26, 8'h80, 5'h18, 1'b1, 1'b0);
    step(21'h26, 8'h80, 5'h18, 1'b0, 1'b0);
    step(21'h28, 8'hF0, 5'h10, 1'b0, 1'b0);
    wrap_up();
  end
endmodule // cpu_add_and_branch_exec_test
`default_nettype wire
